// >>> hw/cnc_status_outputs.sv
// Notes on behaviour
// [R1] Ready after clean self-test, low on fault.
// [R2] Start key press raises start status.
// [R3] Rising cycle-go request clears start status.
// [R4] PLC requests cycle-go only after start status.
// [R5] Feed hold on stop, past halt, hold low.
// [R6] Reset pulse lasts 100 ms per reset.
// [R7] Loop-broken flag on axis loop error.
// [R8] Fault low on alarm until cleared.
// [R9] Emergency output low while fault low.
// [R10] PLC emergency follows ready and fault.
// [R11] One flag per selected operating mode.
// [R12] Conversational flag one for conversational modes.
// [R13] Running from start until end or halt.
// [R14] Single block or jog ends running early.
// [R15] Jog key held keeps running high.
// [R16] One flag per executing motion type.
// [R17] Rigid tap mill only, CONSTANT_SURFACE_SPEED_ON lathe only.
// [R18] Retrace done when all blocks retraced.
// [R19] Raw and applied switch codes reported separately.
// [R20] Jog code in bits three to zero.
// [R21] Feed override code in bits seven to four.
// [R22] Inhibited feed takes nearest allowed below.
// [R23] All outputs update together on one clock.
module cnc_status_outputs #(
  parameter int RESET_PULSE_LEN = cnc_status_pkg::RESET_PULSE_CYCLES
) (
  input  wire logic                                i_mclk,
  input  wire logic                                i_rst,
  input  wire logic [cnc_status_pkg::ADDR_W-1:0]   i_address,
  input  wire logic                                i_read,
  input  wire logic                                i_write,
  input  wire logic [cnc_status_pkg::DATA_W-1:0]   i_writedata,
  input  wire logic [cnc_status_pkg::BE_W-1:0]     i_byteenable,
  output logic      [cnc_status_pkg::DATA_W-1:0]   o_readdata,
  output logic                                     o_waitrequest,
  input  wire logic                                i_selftest_done,
  input  wire logic                                i_selftest_ok,
  input  wire logic                                i_hw_fault,
  input  wire logic                                i_alarm_cause,
  input  wire logic                                i_start_key,
  input  wire logic                                i_stop_key,
  input  wire logic                                i_reset_key,
  input  wire logic                                i_jog_key,
  input  wire logic                                i_cycle_go_request,
  input  wire logic                                i_halt_n,
  input  wire logic                                i_feed_hold_n,
  input  wire logic                                i_reset_request_in,
  input  wire logic [cnc_status_pkg::SWITCH_W-1:0] i_switch_pos,
  output logic                                     o_controller_ok,
  output logic                                     o_start_key_status,
  output logic                                     o_feed_hold_status,
  output logic                                     o_reset_pulse_out,
  output logic                                     o_position_loop_broken,
  output logic                                     o_fault_n,
  output logic                                     o_emergency_n,
  output logic                                     o_jog_mode,
  output logic                                     o_auto_mode_active,
  output logic                                     o_manual_data_input_mode,
  output logic                                     o_single_block_mode,
  output logic                                     o_conversational_mode_flag,
  output logic                                     o_program_running,
  output logic                                     o_rapid_active,
  output logic                                     o_canned_tap_cycle_active,
  output logic                                     o_screw_cut_active,
  output logic                                     o_touch_measure_active,
  output logic                                     o_home_search_active,
  output logic                                     o_synchronous_tap_active,
  output logic                                     o_constant_surface_speed_on,
  output logic                                     o_retrace_done,
  output logic [cnc_status_pkg::SWITCH_W-1:0]      o_raw_switch_code,
  output logic [cnc_status_pkg::SWITCH_W-1:0]      o_applied_switch_code
);
  import cnc_status_pkg::*;

  // ==========================================================
  // Register bus slave with one wait cycle per access.
  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val,
    input logic [BE_W-1:0]   be
  );
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int b = 0; b < BE_W; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  logic                 req;
  logic                 wr_now;
  logic [DATA_W-1:0]    mode_reg;
  logic [DATA_W-1:0]    motion_reg;
  logic [DATA_W-1:0]    inhibit_reg;
  logic [DATA_W-1:0]    event_next;
  logic [DATA_W-1:0]    rd_next;
  logic [DATA_W-1:0]    status_word;
  logic [SWITCH_W-1:0]  applied_next;

  assign req    = i_read | i_write;
  assign wr_now = i_write & ~o_waitrequest;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_waitrequest <= 1'b1;
    end else begin
      o_waitrequest <= ~(req & o_waitrequest);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      mode_reg    <= RESET_ZERO;
      motion_reg  <= RESET_ZERO;
      inhibit_reg <= RESET_ZERO;
    end else if (wr_now) begin
      if (i_address == ADDR_MODE) begin
        mode_reg <= merge_bytes(mode_reg, i_writedata, i_byteenable)
                    & DATA_W'((1 << MODE_W) - 1);
      end
      if (i_address == ADDR_MOTION) begin
        motion_reg <= merge_bytes(motion_reg, i_writedata,
                                  i_byteenable)
                      & DATA_W'((1 << MOT_W) - 1);
      end
      if (i_address == ADDR_INHIBIT) begin
        inhibit_reg <= merge_bytes(inhibit_reg, i_writedata,
                                   i_byteenable)
                       & DATA_W'((1 << INHIBIT_W) - 1);
      end
    end
  end

  always_comb begin
    if (wr_now && i_address == ADDR_EVENT) begin
      event_next = merge_bytes(RESET_ZERO, i_writedata, i_byteenable);
    end else begin
      event_next = RESET_ZERO;
    end
  end

  always_comb begin
    status_word = RESET_ZERO;
    status_word[0]  = o_controller_ok;
    status_word[1]  = o_start_key_status;
    status_word[2]  = o_feed_hold_status;
    status_word[3]  = o_reset_pulse_out;
    status_word[4]  = o_position_loop_broken;
    status_word[5]  = o_fault_n;
    status_word[6]  = o_emergency_n;
    status_word[7]  = o_program_running;
    status_word[8]  = o_retrace_done;
  end

  always_comb begin
    unique case (i_address)
      ADDR_MODE:    rd_next = mode_reg;
      ADDR_MOTION:  rd_next = motion_reg;
      ADDR_INHIBIT: rd_next = inhibit_reg;
      ADDR_STATUS:  rd_next = status_word;
      ADDR_SWITCH:  rd_next = {16'h0000, o_applied_switch_code,
                               o_raw_switch_code};
      default:      rd_next = RESET_ZERO;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_readdata <= RESET_ZERO;
    end else if (i_read && o_waitrequest) begin
      o_readdata <= rd_next;
    end
  end

  // ==========================================================
  // Readiness, alarm and emergency.
  logic msg_pending_reg;
  logic fault_now;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_controller_ok <= 1'b0;
    end else if (i_hw_fault) begin
      o_controller_ok <= 1'b0; // [R1]
    end else if (i_selftest_done && i_selftest_ok) begin
      o_controller_ok <= 1'b1; // [R1]
    end
  end

  // The message stays until software clears it; a new alarm wins.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      msg_pending_reg <= 1'b0;
    end else if (i_alarm_cause || event_next[EV_ALARM]) begin
      msg_pending_reg <= 1'b1;
    end else if (event_next[EV_MSG_CLEAR]) begin
      msg_pending_reg <= 1'b0;
    end
  end

  assign fault_now = i_alarm_cause | msg_pending_reg
                     | event_next[EV_ALARM];

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_fault_n     <= 1'b1;
      o_emergency_n <= 1'b1;
    end else begin
      o_fault_n     <= ~fault_now; // [R8]
      o_emergency_n <= ~fault_now; // [R9]
    end
  end

  // ==========================================================
  // Cycle start handshake, feed hold and reset pulse.
  logic go_prev_reg;
  logic go_rise;
  logic rst_req_prev_reg;
  logic reset_event;
  logic pulse_active;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      go_prev_reg      <= 1'b0;
      rst_req_prev_reg <= 1'b0;
    end else begin
      go_prev_reg      <= i_cycle_go_request;
      rst_req_prev_reg <= i_reset_request_in;
    end
  end

  assign go_rise     = i_cycle_go_request & ~go_prev_reg;
  assign reset_event = i_reset_key
                       | (i_reset_request_in & ~rst_req_prev_reg);

  // A key press in the clearing cycle keeps the status set.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_start_key_status <= 1'b0;
    end else if (i_start_key) begin
      o_start_key_status <= 1'b1; // [R2]
    end else if (go_rise || reset_event) begin
      o_start_key_status <= 1'b0; // [R3] [R4]
    end
  end

  logic hold_latch_reg;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      hold_latch_reg <= 1'b0;
    end else if (i_stop_key || !i_halt_n) begin
      hold_latch_reg <= 1'b1;
    end else if (go_rise || reset_event) begin
      hold_latch_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_feed_hold_status <= 1'b0;
    end else begin
      o_feed_hold_status <= hold_latch_reg | i_stop_key | ~i_halt_n
                            | ~i_feed_hold_n; // [R5]
    end
  end

  reset_pulse_timer #(
    .CYCLES (RESET_PULSE_LEN)
  ) u_reset_pulse (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_trigger (reset_event),
    .o_active  (pulse_active)
  );

  assign o_reset_pulse_out = pulse_active; // [R6]

  // ==========================================================
  // Program running.
  logic run_latch_reg;
  logic run_stop;

  assign run_stop = event_next[EV_PROG_DONE] | i_stop_key | ~i_halt_n
                    | reset_event
                    | (mode_reg[MODE_SINGLE] & event_next[EV_BLOCK_DONE])
                    | (mode_reg[MODE_JOG] & event_next[EV_POS_REACH]);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      run_latch_reg <= 1'b0;
    end else if (run_stop) begin
      run_latch_reg <= 1'b0; // [R13] [R14]
    end else if (go_rise) begin
      run_latch_reg <= 1'b1; // [R13]
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_program_running <= 1'b0;
    end else begin
      o_program_running <= (run_latch_reg & ~run_stop)
                           | motion_reg[MOT_BLOCK_BUSY] // [R13]
                           | (mode_reg[MODE_JOG] & i_jog_key); // [R15]
    end
  end

  // ==========================================================
  // Mode, motion and switch flags, all from one clock edge.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_jog_mode                  <= 1'b0;
      o_auto_mode_active          <= 1'b0;
      o_manual_data_input_mode    <= 1'b0;
      o_single_block_mode         <= 1'b0;
      o_conversational_mode_flag  <= 1'b0;
      o_position_loop_broken      <= 1'b0;
      o_rapid_active              <= 1'b0;
      o_canned_tap_cycle_active   <= 1'b0;
      o_screw_cut_active          <= 1'b0;
      o_touch_measure_active      <= 1'b0;
      o_home_search_active        <= 1'b0;
      o_synchronous_tap_active    <= 1'b0;
      o_constant_surface_speed_on <= 1'b0;
      o_retrace_done              <= 1'b0;
      o_raw_switch_code           <= '0;
      o_applied_switch_code       <= '0;
    end else begin // [R23]
      o_jog_mode                 <= mode_reg[MODE_JOG]; // [R11]
      o_auto_mode_active         <= mode_reg[MODE_AUTO]; // [R11]
      o_manual_data_input_mode   <= mode_reg[MODE_MDI]; // [R11]
      o_single_block_mode        <= mode_reg[MODE_SINGLE]; // [R11]
      o_conversational_mode_flag <= mode_reg[MODE_CONV]; // [R12]
      o_position_loop_broken     <= motion_reg[MOT_LOOP_ERR]; // [R7]
      o_rapid_active             <= motion_reg[MOT_RAPID]; // [R16]
      o_canned_tap_cycle_active  <= motion_reg[MOT_TAP]; // [R16]
      o_screw_cut_active         <= motion_reg[MOT_SCREW]; // [R16]
      o_touch_measure_active     <= motion_reg[MOT_TOUCH]; // [R16]
      o_home_search_active       <= motion_reg[MOT_HOME]; // [R16]
      o_synchronous_tap_active   <= motion_reg[MOT_RIGID]
                                    & ~mode_reg[MODE_LATHE]; // [R17]
      o_constant_surface_speed_on <= motion_reg[MOT_CSS]
                                     & mode_reg[MODE_LATHE]; // [R17]
      o_retrace_done             <= motion_reg[MOT_RETRACE_ON]
                                    & motion_reg[MOT_RETRACE_OK]; // [R18]
      o_raw_switch_code          <= i_switch_pos; // [R19] [R20] [R21]
      o_applied_switch_code      <= applied_next; // [R19]
    end
  end

  switch_apply u_switch_apply (
    .i_raw     (i_switch_pos),
    .i_inhibit (inhibit_reg[INHIBIT_W-1:0]),
    .o_applied (applied_next)
  );

  // ==========================================================
  // Checks.
  start_clear_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R3]
    go_rise && !i_start_key |=> !o_start_key_status)
    else $error("start status not cleared by go edge");

  start_set_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R2]
    i_start_key |=> o_start_key_status)
    else $error("start key not reported");

  hold_stick_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R5]
    !i_halt_n ##1 (i_halt_n && !go_rise && !reset_event) |=>
      o_feed_hold_status)
    else $error("feed hold lost after halt released");

  pulse_len_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R6]
    reset_event |=> o_reset_pulse_out [*8])
    else $error("reset pulse too short");

  emerg_follow_a: assert property (@(posedge i_mclk) // [R9]
    disable iff (i_rst) !o_fault_n |-> !o_emergency_n)
    else $error("emergency not held with fault");

  fault_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R8]
    i_alarm_cause ##1 (!i_alarm_cause && !event_next[EV_MSG_CLEAR])
      |=> !o_fault_n)
    else $error("fault released before message cleared");

  ready_drop_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R1]
    i_hw_fault |=> !o_controller_ok)
    else $error("ready kept high on hardware fault");

  run_single_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R14]
    mode_reg[MODE_SINGLE] && event_next[EV_BLOCK_DONE]
      && !motion_reg[MOT_BLOCK_BUSY] && !mode_reg[MODE_JOG]
      |=> !o_program_running)
    else $error("running kept after single block");

  model_only_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R17]
    !(o_synchronous_tap_active && o_constant_surface_speed_on))
    else $error("rigid tap and surface speed on one model");

  feed_code_a: assert property (@(posedge i_mclk) disable iff (i_rst) // [R22]
    inhibit_reg[FEED_LSB +: FEED_POSNS] == '0 && $stable(i_switch_pos)
      |=> o_applied_switch_code[7:4] == o_raw_switch_code[7:4])
    else $error("applied feed code differs without inhibit");

endmodule

// >>> hw/cnc_status_pkg.sv
package cnc_status_pkg;

  // ==========================================================
  // Bus and register map
  localparam int          ADDR_W       = 5;
  localparam int          DATA_W       = 32;
  localparam int          BE_W         = 4;
  localparam logic [4:0]  ADDR_MODE    = 5'h00;
  localparam logic [4:0]  ADDR_MOTION  = 5'h04;
  localparam logic [4:0]  ADDR_EVENT   = 5'h08;
  localparam logic [4:0]  ADDR_INHIBIT = 5'h0C;
  localparam logic [4:0]  ADDR_STATUS  = 5'h10;
  localparam logic [4:0]  ADDR_SWITCH  = 5'h14;
  localparam logic [31:0] RESET_ZERO   = 32'h0000_0000;

  // ==========================================================
  // Mode register fields
  localparam int MODE_JOG    = 0;
  localparam int MODE_AUTO   = 1;
  localparam int MODE_MDI    = 2;
  localparam int MODE_SINGLE = 3;
  localparam int MODE_CONV   = 4;
  localparam int MODE_LATHE  = 5;
  localparam int MODE_W      = 6;

  // ==========================================================
  // Motion register fields
  localparam int MOT_RAPID      = 0;
  localparam int MOT_TAP        = 1;
  localparam int MOT_SCREW      = 2;
  localparam int MOT_TOUCH      = 3;
  localparam int MOT_HOME       = 4;
  localparam int MOT_RIGID      = 5;
  localparam int MOT_CSS        = 6;
  localparam int MOT_RETRACE_ON = 7;
  localparam int MOT_RETRACE_OK = 8;
  localparam int MOT_BLOCK_BUSY = 9;
  localparam int MOT_LOOP_ERR   = 10;
  localparam int MOT_W          = 11;

  // ==========================================================
  // Event register fields, write one to pulse
  localparam int EV_PROG_DONE  = 0;
  localparam int EV_BLOCK_DONE = 1;
  localparam int EV_POS_REACH  = 2;
  localparam int EV_MSG_CLEAR  = 3;
  localparam int EV_ALARM      = 4;

  // ==========================================================
  // Switch codes and inhibit word layout
  localparam int          INHIBIT_W   = 23;
  localparam int          JOG_LSB     = 0;
  localparam int          JOG_POSNS   = 8;
  localparam int          FEED_LSB    = 8;
  localparam int          FEED_POSNS  = 15;
  localparam int          CODE_W      = 4;
  localparam int          SWITCH_W    = 8;
  localparam logic [3:0]  CODE_LOWEST = 4'h0;

  // ==========================================================
  // Timing
  localparam int CLK_FREQ_HZ    = 50_000_000;
  localparam int RESET_PULSE_MS = 100;
  localparam int MS_PER_S       = 1000;
  localparam int RESET_PULSE_CYCLES =
    CLK_FREQ_HZ / MS_PER_S * RESET_PULSE_MS;
  localparam int PULSE_CNT_W    = 24;

endpackage

// >>> hw/reset_pulse_timer.sv
module reset_pulse_timer #(
  parameter int CYCLES = cnc_status_pkg::RESET_PULSE_CYCLES
) (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_trigger,
  output logic      o_active
);
  import cnc_status_pkg::*;

  logic [PULSE_CNT_W-1:0] count_reg;

  // ==========================================================
  // A new trigger restarts the full pulse length.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      count_reg <= '0;
      o_active  <= 1'b0;
    end else if (i_trigger) begin
      count_reg <= PULSE_CNT_W'(CYCLES - 1);
      o_active  <= 1'b1;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end else begin
      o_active <= 1'b0;
    end
  end

endmodule

// >>> hw/switch_apply.sv
module switch_apply (
  input  wire logic [cnc_status_pkg::SWITCH_W-1:0]  i_raw,
  input  wire logic [cnc_status_pkg::INHIBIT_W-1:0] i_inhibit,
  output logic      [cnc_status_pkg::SWITCH_W-1:0]  o_applied
);
  import cnc_status_pkg::*;

  // ==========================================================
  // Nearest allowed position at or below the selected one.
  function automatic logic [CODE_W-1:0] pick_below(
    input logic [CODE_W-1:0] pos,
    input logic [15:0]       allowed
  );
    logic [CODE_W-1:0] res;
    res = CODE_LOWEST;
    for (int i = 0; i < 16; i++) begin
      if (allowed[i] && (CODE_W'(i) <= pos)) begin
        res = CODE_W'(i);
      end
    end
    return res;
  endfunction

  logic [15:0] jog_ok;
  logic [15:0] feed_ok;
  logic [3:0]  jog_raw;
  logic [3:0]  feed_raw;

  assign jog_raw  = i_raw[3:0];
  assign feed_raw = i_raw[7:4];
  assign jog_ok   = {8'h00, ~i_inhibit[JOG_LSB +: JOG_POSNS]};
  assign feed_ok  = {1'b0, ~i_inhibit[FEED_LSB +: FEED_POSNS]};

  always_comb begin
    o_applied[7:4] = pick_below(feed_raw, feed_ok); // [R22]
    if (jog_raw >= CODE_W'(JOG_POSNS)) begin
      o_applied[3:0] = jog_raw;
    end else begin
      o_applied[3:0] = pick_below(jog_raw, jog_ok);
    end
  end

endmodule

// >>> testbench/plc_model.sv
// ==========================================================
// PLC side: starts the program once the start status is seen.
module plc_model (
  input  wire logic i_mclk,
  input  wire logic i_start_status,
  input  wire logic i_ok,
  input  wire logic i_fault_n,
  output logic      o_go,
  output logic      o_emerg
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_go = 1'h0;
  always @(posedge i_mclk) begin
    o_go <= i_start_status;
  end
  assign o_emerg = i_ok & i_fault_n;
endmodule

// >>> testbench/tb_cnc_status_outputs.sv
module tb_cnc_status_outputs;
  timeunit 1ns;
  timeprecision 1ns;
  import cnc_status_pkg::*;
  // ==========================================================
  // Signals, design and PLC model.
  logic i_mclk = 0, i_rst = 1, i_read = 0, i_write = 0, i_hw_fault = 0;
  logic [4:0] i_address = 0;
  logic [31:0] i_writedata = 0, o_readdata, rdat, rnd = 32'h7BDA;
  logic [3:0] i_byteenable = 4'hF;
  logic i_selftest_done = 0, i_selftest_ok = 0, i_alarm_cause = 0;
  logic i_start_key = 0, i_stop_key = 0, i_reset_key = 0, i_jog_key = 0;
  logic i_halt_n = 1, i_feed_hold_n = 1, i_reset_request_in = 0;
  logic i_cycle_go_request, plc_emerg, o_waitrequest, o_controller_ok;
  logic o_start_key_status, o_feed_hold_status, o_reset_pulse_out;
  logic o_position_loop_broken, o_fault_n, o_emergency_n, o_jog_mode;
  logic o_auto_mode_active, o_manual_data_input_mode, o_single_block_mode;
  logic o_conversational_mode_flag, o_program_running, o_rapid_active;
  logic o_canned_tap_cycle_active, o_screw_cut_active, o_retrace_done;
  logic o_touch_measure_active, o_home_search_active;
  logic o_synchronous_tap_active, o_constant_surface_speed_on;
  logic [7:0] i_switch_pos = 0, o_raw_switch_code, o_applied_switch_code;
  logic [7:0] e8;
  logic [22:0] h;
  logic [4:0] modes;
  logic [8:0] mot;
  int failures = 0, checked = 0, n, k;
  cnc_status_outputs #(.RESET_PULSE_LEN(16)) i_dut (
    .i_mclk, .i_rst, .i_address, .i_read, .i_write, .i_writedata,
    .i_byteenable, .o_readdata, .o_waitrequest, .i_selftest_done,
    .i_selftest_ok, .i_hw_fault, .i_alarm_cause, .i_start_key, .i_stop_key,
    .i_reset_key, .i_jog_key, .i_cycle_go_request, .i_halt_n,
    .i_feed_hold_n, .i_reset_request_in, .i_switch_pos, .o_controller_ok,
    .o_start_key_status, .o_feed_hold_status, .o_reset_pulse_out,
    .o_position_loop_broken, .o_fault_n, .o_emergency_n, .o_jog_mode,
    .o_auto_mode_active, .o_manual_data_input_mode, .o_single_block_mode,
    .o_conversational_mode_flag, .o_program_running, .o_rapid_active,
    .o_canned_tap_cycle_active, .o_screw_cut_active,
    .o_touch_measure_active, .o_home_search_active,
    .o_synchronous_tap_active, .o_constant_surface_speed_on,
    .o_retrace_done, .o_raw_switch_code, .o_applied_switch_code);
  plc_model i_plc (.i_mclk, .i_start_status(o_start_key_status),
    .i_ok(o_controller_ok), .i_fault_n(o_fault_n),
    .o_go(i_cycle_go_request), .o_emerg(plc_emerg));
  assign modes = {o_conversational_mode_flag, o_single_block_mode,
    o_manual_data_input_mode, o_auto_mode_active, o_jog_mode};
  assign mot = {o_position_loop_broken, o_retrace_done,
    o_constant_surface_speed_on, o_synchronous_tap_active,
    o_home_search_active, o_touch_measure_active, o_screw_cut_active,
    o_canned_tap_cycle_active, o_rapid_active};
  always #10 i_mclk = ~i_mclk;
  // ==========================================================
  // Helpers.
  task automatic cy(int c);
    repeat (c) @(posedge i_mclk);
  endtask
  task automatic chk(logic [31:0] g, logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus(logic w, logic [4:0] a, logic [31:0] d);
    @(posedge i_mclk);
    i_address <= a;
    i_write <= w;
    i_read <= !w;
    i_writedata <= d;
    do @(posedge i_mclk); while (o_waitrequest !== 1'h0);
    rdat = o_readdata;
    i_read <= 1'h0;
    i_write <= 1'h0;
  endtask
  task automatic press;
    i_start_key <= 1'h1;
    cy(1);
    i_start_key <= 1'h0;
    cy(1);
  endtask
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Lower inhibited positions fall to the nearest allowed one below.
  function automatic logic [7:0] appl(logic [7:0] p, logic [22:0] m);
    logic [3:0] j, f;
    j = p[3:0];
    f = p[7:4];
    if (j < 8) while (j > 0 && m[j]) j--;
    while (f > 0 && m[8 + f]) f--;
    return {f, j};
  endfunction
  task automatic give_verdict;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // Main sequence and watchdog.
  initial begin
    repeat (4000) @(posedge i_mclk);
    failures++;
    give_verdict;
  end
  initial begin
    cy(8);
    i_rst <= 1'h0;
    bus(0, ADDR_STATUS, 0);
    chk(rdat, 32'h60);
    bus(0, 5'h18, 0);
    chk(rdat, 32'h0);
    i_selftest_done <= 1'h1;
    i_selftest_ok <= 1'h1;
    cy(2);
    chk(o_controller_ok, 1'h1);
    press;
    chk(o_start_key_status, 1'h1);
    cy(3);
    chk({o_start_key_status, o_program_running}, 2'h1);
    i_stop_key <= 1'h1;
    cy(1);
    i_stop_key <= 1'h0;
    cy(1);
    chk({o_feed_hold_status, o_program_running}, 2'h2);
    bus(1, ADDR_MODE, 32'h8);
    press;
    cy(3);
    chk(o_program_running, 1'h1);
    bus(1, ADDR_EVENT, 32'h2);
    cy(2);
    chk(o_program_running, 1'h0);
    i_feed_hold_n <= 1'h0;
    cy(2);
    chk(o_feed_hold_status, 1'h1);
    i_feed_hold_n <= 1'h1;
    cy(2);
    chk(o_feed_hold_status, 1'h0);
    i_halt_n <= 1'h0;
    cy(1);
    i_halt_n <= 1'h1;
    cy(3);
    chk(o_feed_hold_status, 1'h1);
    bus(1, ADDR_MODE, 32'h1);
    i_jog_key <= 1'h1;
    cy(2);
    chk(o_program_running, 1'h1);
    i_jog_key <= 1'h0;
    cy(2);
    chk(o_program_running, 1'h0);
    for (n = 0; n < 5; n++) begin
      bus(1, ADDR_MODE, 32'h1 << n);
      cy(2);
      chk(modes, 32'h1 << n);
    end
    for (n = 0; n < 8; n++) begin
      rnd = xs(rnd);
      bus(1, ADDR_MODE, {26'h0, n[0], 5'h0});
      bus(1, ADDR_MOTION, {21'h0, rnd[10:0]});
      cy(2);
      chk(mot, {rnd[10], rnd[7] & rnd[8], rnd[6] & n[0], rnd[5] & !n[0],
        rnd[4:0]});
    end
    for (n = 0; n < 16; n++) begin
      rnd = xs(rnd);
      e8 = {rnd[7:4] % 4'hF, rnd[3:0] % 4'h9};
      h = (n == 0) ? '1 : rnd[31:9];
      i_switch_pos <= e8;
      bus(1, ADDR_INHIBIT, {9'h0, h});
      cy(2);
      chk({o_applied_switch_code, o_raw_switch_code},
        {appl(e8, h), e8});
    end
    for (n = 0; n < 2; n++) begin
      if (n == 0) i_reset_request_in <= 1'h1;
      else i_reset_key <= 1'h1;
      cy(1);
      i_reset_request_in <= 1'h0;
      i_reset_key <= 1'h0;
      k = 0;
      repeat (40) begin
        cy(1);
        k += o_reset_pulse_out;
      end
      chk(k, 32'h10);
    end
    i_alarm_cause <= 1'h1;
    cy(2);
    chk({o_fault_n, o_emergency_n, plc_emerg}, 3'h0);
    i_alarm_cause <= 1'h0;
    cy(2);
    chk(o_fault_n, 1'h0);
    bus(1, ADDR_EVENT, 32'h8);
    cy(2);
    chk({o_fault_n, o_emergency_n, plc_emerg}, 3'h7);
    i_hw_fault <= 1'h1;
    cy(2);
    chk({o_controller_ok, plc_emerg}, 2'h0);
    give_verdict;
  end
endmodule
